// ### sfcfe_pkg.sv
`default_nettype none
package sfcfe_pkg;

	// Opcodes handled by the front end.
	localparam logic [7:0] OP_DEEP_SLEEP_ENTRY = 8'hB9;
	localparam logic [7:0] OP_WAKE_AND_IDENTIFY = 8'hAB;
	localparam logic [7:0] OP_STD_IDENT = 8'h9F;
	localparam logic [7:0] OP_PARAM_READ = 8'h5A;
	localparam logic [7:0] OP_PROG_ADDR4 = 8'h12;
	localparam logic [7:0] OP_QPROG_ADDR4 = 8'h34;
	localparam logic [7:0] OP_MAKER_PART = 8'h90;
	localparam logic [7:0] OP_MAKER_PART_X2 = 8'h92;
	localparam logic [7:0] OP_WRAP_SET = 8'h77;
	localparam logic [7:0] OP_STATUS1_READ = 8'h05;
	localparam logic [7:0] OP_STATUS2_READ = 8'h35;
	localparam logic [7:0] OP_STATUS3_READ = 8'h15;
	localparam logic [7:0] OP_SUSPEND = 8'h75;

	// Byte index (opcode is index 0) at which the answer phase starts; 0 means no answer.
	localparam logic [3:0] RESP_NONE = 4'h0;
	localparam logic [3:0] RESP_AT_STATUS = 4'h1;
	localparam logic [3:0] RESP_AT_STD_IDENT = 4'h1;
	localparam logic [3:0] RESP_AT_PARAM = 4'h5;
	localparam logic [3:0] RESP_AT_MAKER_PART = 4'h4;
	localparam logic [3:0] RESP_AT_WAKE = 4'h4;
	localparam logic [3:0] RESP_AT_MAKER_PART_X2 = 4'h5;

	// Byte positions inside the instruction formats.
	localparam logic [3:0] ADDR_LAST_PARAM = 4'h3;
	localparam logic [3:0] ADDR_LAST_PROG = 4'h4;
	localparam logic [3:0] DATA_FIRST_PROG = 4'h5;
	localparam logic [3:0] WRAP_BYTE_IDX = 4'h4;
	localparam logic [3:0] BYTE_IDX_MAX = 4'hF;

	// Lane counts and bit counts per byte.
	localparam logic [3:0] LANES_1 = 4'h1;
	localparam logic [3:0] LANES_2 = 4'h2;
	localparam logic [3:0] LANES_4 = 4'h4;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	// Output enable patterns per lane count.
	localparam logic [3:0] OE_SINGLE = 4'h2;
	localparam logic [3:0] OE_DUAL = 4'h3;
	localparam logic [3:0] OE_QUAD = 4'hF;

	typedef enum logic [1:0] {PWR_STANDBY, PWR_ACTIVE, PWR_DEEP} sfcfe_power_e;
	typedef enum logic [1:0] {PH_IDLE, PH_CMD, PH_IGNORE} sfcfe_phase_e;

	typedef struct packed {
		logic cs_n;
		logic sclk;
		logic [3:0] io;
	} sfcfe_pins_s;

	localparam sfcfe_pins_s PINS_IDLE = '{cs_n: 1'b1, sclk: 1'b0, io: 4'h0};

	typedef struct packed {
		logic sel;
		logic sclk_q;
		sfcfe_phase_e phase;
		logic [7:0] opcode;
		logic [7:0] rx_sh;
		logic [3:0] rx_cnt;
		logic [3:0] byte_idx;
		logic [31:0] addr;
		logic [7:0] wrap_hold;
		logic resp;
		logic [7:0] tx_sh;
		logic [3:0] tx_cnt;
		logic [1:0] tx_idx;
		logic deep;
		logic [7:0] wrap_reg;
		logic [3:0] io_out;
		logic [3:0] io_oe;
		logic commit;
		logic discard;
		logic [7:0] cmd_opcode;
		logic [31:0] cmd_addr;
		logic wr_valid;
		logic [7:0] wr_byte;
		sfcfe_power_e power;
	} sfcfe_state_s;

	localparam sfcfe_state_s STATE_RESET = sfcfe_state_s'('0);

endpackage : sfcfe_pkg
`default_nettype wire

// ### sfcfe_sync.sv
`timescale 1ns/1ps
`default_nettype none
module sfcfe_sync #(
	parameter int WIDTH = 6,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] ff1_reg;
	logic [WIDTH-1:0] ff2_reg;
	logic [WIDTH-1:0] ff3_reg;

	// A bit changes only once the second and third stages agree.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ff1_reg <= RESET_VAL;
			ff2_reg <= RESET_VAL;
			ff3_reg <= RESET_VAL;
			sync_out <= RESET_VAL;
		end else begin
			ff1_reg <= async_in;
			ff2_reg <= ff1_reg;
			ff3_reg <= ff2_reg;
			for (int i = 0; i < WIDTH; i++) begin
				if (ff2_reg[i] == ff3_reg[i]) begin
					sync_out[i] <= ff3_reg[i];
				end
			end
		end
	end

endmodule : sfcfe_sync
`default_nettype wire

// ### sfcfe_front_end.sv
`timescale 1ns/1ps
`default_nettype none
module sfcfe_front_end
	import sfcfe_pkg::*;
#(
	parameter logic [7:0] MAKER_CODE = 8'hC3,
	parameter logic [7:0] MEMORY_TYPE = 8'h41,
	parameter logic [7:0] CAPACITY_CODE = 8'h19,
	parameter logic [7:0] PART_CODE = 8'h27
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic spi_cs_n,
	input wire logic spi_sclk,
	input wire logic [3:0] spi_io_in,
	output logic [3:0] spi_io_out,
	output logic [3:0] spi_io_oe,
	input wire logic four_lane_command_mode,
	input wire logic busy_in,
	input wire logic [7:0] status1_byte,
	input wire logic [7:0] status2_byte,
	input wire logic [7:0] status3_byte,
	input wire logic [7:0] param_data,
	output logic [23:0] param_addr,
	output logic cmd_commit,
	output logic cmd_discard,
	output logic [7:0] cmd_opcode,
	output logic [31:0] cmd_addr,
	output logic wr_valid,
	output logic [7:0] wr_byte,
	output logic [7:0] wrap_setting,
	output logic deep_sleep,
	output sfcfe_power_e power_state
);
	// The identification parameter values are arbitrary.

	logic [1:0] rst_pipe_reg;
	logic rst_n;
	sfcfe_pins_s pins_raw;
	sfcfe_pins_s pins;
	sfcfe_state_s s_reg;
	sfcfe_state_s s_next;

	// Reset leaves through two flip-flops so every register quits it on one edge.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rst_pipe_reg <= 2'h0;
		end else begin
			rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
		end
	end
	assign rst_n = rst_pipe_reg[1];

	assign pins_raw = '{cs_n: spi_cs_n, sclk: spi_sclk, io: spi_io_in};

	// One synchroniser for all pins keeps chip select, clock and data in step.
	sfcfe_sync #(
		.WIDTH($bits(sfcfe_pins_s)),
		.RESET_VAL(PINS_IDLE)
	) u_pin_sync (
		.clock(clock),
		.rst_n(rst_n),
		.async_in(pins_raw),
		.sync_out(pins)
	);

	// Byte index at which an opcode's answer begins; zero for write-type opcodes.
	function automatic logic [3:0] resp_start(input logic [7:0] op);
		case (op)
			OP_STATUS1_READ, OP_STATUS2_READ, OP_STATUS3_READ: resp_start = RESP_AT_STATUS;
			OP_STD_IDENT: resp_start = RESP_AT_STD_IDENT;
			OP_PARAM_READ: resp_start = RESP_AT_PARAM;
			OP_MAKER_PART: resp_start = RESP_AT_MAKER_PART;
			OP_WAKE_AND_IDENTIFY: resp_start = RESP_AT_WAKE;
			OP_MAKER_PART_X2: resp_start = RESP_AT_MAKER_PART_X2;
			default: resp_start = RESP_NONE;
		endcase
	endfunction

	// Opcodes that an internal cycle does not lock out.
	function automatic logic busy_allowed(input logic [7:0] op);
		case (op)
			OP_STATUS1_READ, OP_STATUS2_READ, OP_STATUS3_READ, OP_SUSPEND: busy_allowed = 1'b1;
			default: busy_allowed = 1'b0;
		endcase
	endfunction

	// Input lanes for the byte at index idx of opcode op.
	function automatic logic [3:0] rx_lanes(input logic quad, input logic [7:0] op,
			input logic [3:0] idx);
		if (quad) begin
			rx_lanes = LANES_4;
		end else if (idx == 4'h0) begin
			rx_lanes = LANES_1;
		end else if (op == OP_MAKER_PART_X2) begin
			rx_lanes = LANES_2;
		end else if (op == OP_QPROG_ADDR4 && idx >= DATA_FIRST_PROG) begin
			rx_lanes = LANES_4;
		end else begin
			rx_lanes = LANES_1;
		end
	endfunction

	// Last address byte index of an opcode; zero when it carries no address.
	function automatic logic [3:0] addr_last(input logic [7:0] op);
		case (op)
			OP_PARAM_READ: addr_last = ADDR_LAST_PARAM;
			OP_PROG_ADDR4, OP_QPROG_ADDR4: addr_last = ADDR_LAST_PROG;
			default: addr_last = 4'h0;
		endcase
	endfunction

	// Answer byte number idx of opcode op.
	function automatic logic [7:0] tx_source(input logic [7:0] op, input logic [1:0] idx,
			input logic [7:0] st1, input logic [7:0] st2, input logic [7:0] st3,
			input logic [7:0] pdata);
		case (op)
			OP_STATUS1_READ: tx_source = st1;
			OP_STATUS2_READ: tx_source = st2;
			OP_STATUS3_READ: tx_source = st3;
			OP_STD_IDENT: begin
				case (idx)
					2'h0: tx_source = MAKER_CODE;
					2'h1: tx_source = MEMORY_TYPE;
					2'h2: tx_source = CAPACITY_CODE;
					default: tx_source = 8'h00;
				endcase
			end
			OP_PARAM_READ: tx_source = pdata;
			OP_MAKER_PART, OP_MAKER_PART_X2: tx_source = idx[0] ? PART_CODE : MAKER_CODE;
			OP_WAKE_AND_IDENTIFY: tx_source = PART_CODE;
			default: tx_source = 8'h00;
		endcase
	endfunction

	// Pulse outputs drop after one cycle unless they are set again below.
	always_comb begin
		logic rise;
		logic fall;
		logic [3:0] lanes;
		logic [3:0] cnt_sum;
		logic [7:0] rx_byte;
		logic [7:0] op_now;
		logic [7:0] cur;
		logic [3:0] out_lanes;
		rise = 1'b0;
		fall = 1'b0;
		lanes = LANES_1;
		cnt_sum = 4'h0;
		rx_byte = 8'h00;
		op_now = 8'h00;
		cur = 8'h00;
		out_lanes = LANES_1;
		s_next = s_reg;
		s_next.commit = 1'b0;
		s_next.discard = 1'b0;
		s_next.wr_valid = 1'b0;
		s_next.sclk_q = pins.sclk;
		rise = pins.sclk & ~s_reg.sclk_q;
		fall = ~pins.sclk & s_reg.sclk_q;
		if (pins.cs_n) begin
			// Reads end silently at any bit after their opcode byte; only write-type instructions commit or discard.
			if (s_reg.sel && s_reg.phase == PH_CMD
					&& resp_start(s_reg.opcode) == RESP_NONE) begin
				if (s_reg.rx_cnt == 4'h0 && s_reg.byte_idx != 4'h0) begin
					s_next.commit = 1'b1;
					s_next.cmd_opcode = s_reg.opcode;
					s_next.cmd_addr = s_reg.addr;
					if (s_reg.opcode == OP_DEEP_SLEEP_ENTRY) begin
						s_next.deep = 1'b1;
					end
					// The wrap setting only takes effect once its byte is complete.
					if (s_reg.opcode == OP_WRAP_SET && s_reg.byte_idx > WRAP_BYTE_IDX) begin
						s_next.wrap_reg = s_reg.wrap_hold;
					end
				end else begin
					s_next.discard = 1'b1;
				end
			end
			s_next.sel = 1'b0;
			s_next.phase = PH_IDLE;
			s_next.resp = 1'b0;
			s_next.io_oe = 4'h0;
			s_next.io_out = 4'h0;
		// A new selection clears what is left of the previous instruction.
		end else if (!s_reg.sel) begin
			s_next.sel = 1'b1;
			s_next.phase = PH_CMD;
			s_next.opcode = 8'h00;
			s_next.rx_cnt = 4'h0;
			s_next.byte_idx = 4'h0;
			s_next.addr = 32'h0;
			s_next.resp = 1'b0;
			s_next.tx_cnt = 4'h0;
			s_next.tx_idx = 2'h0;
		end else begin
			// Bits are decoded only until the answer phase starts.
			if (rise && s_reg.phase == PH_CMD && !s_reg.resp) begin
				lanes = rx_lanes(four_lane_command_mode, s_reg.opcode, s_reg.byte_idx);
				case (lanes)
					LANES_4: rx_byte = {s_reg.rx_sh[3:0], pins.io};
					LANES_2: rx_byte = {s_reg.rx_sh[5:0], pins.io[1:0]};
					default: rx_byte = {s_reg.rx_sh[6:0], pins.io[0]};
				endcase
				s_next.rx_sh = rx_byte;
				cnt_sum = s_reg.rx_cnt + lanes;
				if (cnt_sum == BITS_PER_BYTE) begin
					s_next.rx_cnt = 4'h0;
					op_now = (s_reg.byte_idx == 4'h0) ? rx_byte : s_reg.opcode;
					if (s_reg.byte_idx != BYTE_IDX_MAX) begin
						s_next.byte_idx = s_reg.byte_idx + 4'h1;
					end
					if (s_reg.byte_idx == 4'h0) begin
						s_next.opcode = rx_byte;
						// The lockout checks are made once, when the opcode byte is complete.
						if (s_reg.deep && rx_byte != OP_WAKE_AND_IDENTIFY) begin
							s_next.phase = PH_IGNORE;
						end else if (busy_in && !busy_allowed(rx_byte)) begin
							s_next.phase = PH_IGNORE;
						end else if (rx_byte == OP_WAKE_AND_IDENTIFY) begin
							s_next.deep = 1'b0;
						end
					// Address bytes arrive highest first and shift in from the bottom.
					end else if (s_reg.byte_idx <= addr_last(op_now)) begin
						s_next.addr = {s_reg.addr[23:0], rx_byte};
					end else if ((op_now == OP_PROG_ADDR4 || op_now == OP_QPROG_ADDR4)
							&& s_reg.byte_idx >= DATA_FIRST_PROG) begin
						s_next.wr_valid = 1'b1;
						s_next.wr_byte = rx_byte;
					end else if (op_now == OP_WRAP_SET && s_reg.byte_idx == WRAP_BYTE_IDX) begin
						s_next.wrap_hold = rx_byte;
					end
					if (s_next.phase == PH_CMD && resp_start(op_now) != RESP_NONE
							&& s_reg.byte_idx + 4'h1 == resp_start(op_now)) begin
						s_next.resp = 1'b1;
					end
				end else begin
					s_next.rx_cnt = cnt_sum;
				end
			end
			// Every falling edge in the answer phase moves the next bits out.
			if (fall && s_reg.resp) begin
				if (four_lane_command_mode) begin
					out_lanes = LANES_4;
				end else if (s_reg.opcode == OP_MAKER_PART_X2) begin
					out_lanes = LANES_2;
				end else begin
					out_lanes = LANES_1;
				end
				// A new answer byte is fetched once the previous one is fully sent.
				if (s_reg.tx_cnt == 4'h0) begin
					cur = tx_source(s_reg.opcode, s_reg.tx_idx, status1_byte, status2_byte,
						status3_byte, param_data);
					s_next.tx_idx = s_reg.tx_idx + 2'h1;
					if (s_reg.opcode == OP_PARAM_READ) begin
						s_next.addr = s_reg.addr + 32'h1;
					end
				end else begin
					cur = s_reg.tx_sh;
				end
				// Single answers use line 1, dual lines 1 and 0, quad all four.
				case (out_lanes)
					LANES_4: begin
						s_next.io_out = cur[7:4];
						s_next.io_oe = OE_QUAD;
						s_next.tx_sh = {cur[3:0], 4'h0};
						s_next.tx_cnt = (s_reg.tx_cnt == 4'h0) ? 4'h1 : s_reg.tx_cnt - 4'h1;
					end
					LANES_2: begin
						s_next.io_out = {2'h0, cur[7:6]};
						s_next.io_oe = OE_DUAL;
						s_next.tx_sh = {cur[5:0], 2'h0};
						s_next.tx_cnt = (s_reg.tx_cnt == 4'h0) ? 4'h3 : s_reg.tx_cnt - 4'h1;
					end
					default: begin
						s_next.io_out = {2'h0, cur[7], 1'b0};
						s_next.io_oe = OE_SINGLE;
						s_next.tx_sh = {cur[6:0], 1'b0};
						s_next.tx_cnt = (s_reg.tx_cnt == 4'h0) ? 4'h7 : s_reg.tx_cnt - 4'h1;
					end
				endcase
			end
		end
		// Power follows deep sleep first, then selection and the internal cycle.
		if (s_next.deep) begin
			s_next.power = PWR_DEEP;
		end else if (!pins.cs_n || busy_in) begin
			s_next.power = PWR_ACTIVE;
		end else begin
			s_next.power = PWR_STANDBY;
		end
	end

	// All state except the reset pipe and the pin synchroniser lives in one struct that is registered here.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s_reg <= STATE_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	// Every output comes straight from a state register.
	assign spi_io_out = s_reg.io_out;
	assign spi_io_oe = s_reg.io_oe;
	assign param_addr = s_reg.addr[23:0];
	assign cmd_commit = s_reg.commit;
	assign cmd_discard = s_reg.discard;
	assign cmd_opcode = s_reg.cmd_opcode;
	assign cmd_addr = s_reg.cmd_addr;
	assign wr_valid = s_reg.wr_valid;
	assign wr_byte = s_reg.wr_byte;
	assign wrap_setting = s_reg.wrap_reg;
	assign deep_sleep = s_reg.deep;
	assign power_state = s_reg.power;

endmodule : sfcfe_front_end
`default_nettype wire

// ### sfcfe_front_end_props.sv
`timescale 1ns/1ps
`default_nettype none
module sfcfe_front_end_props
	import sfcfe_pkg::*;
(
	input wire logic clock,
	input wire logic resetn,
	input wire logic spi_cs_n,
	input wire logic busy_in,
	input wire logic [3:0] spi_io_oe,
	input wire logic cmd_commit,
	input wire logic cmd_discard,
	input wire logic [7:0] cmd_opcode,
	input wire logic wr_valid,
	input wire logic [7:0] wrap_setting,
	input wire logic deep_sleep,
	input wire sfcfe_power_e power_state
);
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	oe_release_a: assert property (spi_cs_n [*8] |-> spi_io_oe == 4'h0)
		else $error("Lines driven while deselected.");
	pulse_excl_a: assert property (cmd_commit |-> !cmd_discard)
		else $error("Commit and discard together.");
	end_deselect_a: assert property ((cmd_commit || cmd_discard) |-> $past(spi_cs_n, 2))
		else $error("Instruction ended while selected.");
	deep_state_a: assert property (deep_sleep |-> power_state == PWR_DEEP)
		else $error("Deep sleep without deep power state.");
	active_sel_a: assert property ((!spi_cs_n && !deep_sleep) [*6] |-> power_state == PWR_ACTIVE)
		else $error("Selected but not active.");
	standby_idle_a: assert property ((spi_cs_n && !busy_in && !deep_sleep) [*6]
		|-> power_state == PWR_STANDBY)
		else $error("Idle but not standby.");
	busy_active_a: assert property (busy_in && !deep_sleep |=> power_state != PWR_STANDBY)
		else $error("Standby while busy.");
	deep_hold_a: assert property ((deep_sleep && spi_cs_n) [*8] |=> deep_sleep)
		else $error("Deep sleep left while deselected.");
	wr_single_a: assert property (wr_valid |=> !wr_valid)
		else $error("Data pulse longer than one cycle.");
	wrap_cause_a: assert property (!$stable(wrap_setting)
		|-> cmd_commit && cmd_opcode == OP_WRAP_SET)
		else $error("Wrap changed without wrap commit.");
	discard_keep_a: assert property (cmd_discard |-> $stable(cmd_opcode))
		else $error("Discard changed the opcode.");
endmodule : sfcfe_front_end_props
bind sfcfe_front_end sfcfe_front_end_props sfcfe_front_end_props_inst (
	.clock(clock), .resetn(resetn), .spi_cs_n(spi_cs_n), .busy_in(busy_in),
	.spi_io_oe(spi_io_oe), .cmd_commit(cmd_commit), .cmd_discard(cmd_discard),
	.cmd_opcode(cmd_opcode), .wr_valid(wr_valid), .wrap_setting(wrap_setting),
	.deep_sleep(deep_sleep), .power_state(power_state)
);
`default_nettype wire

// ### sfcfe_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module sfcfe_host_model (
	input wire logic clock,
	input wire logic [3:0] line,
	output logic cs_n,
	output logic sclk,
	output logic [3:0] io
);
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		io = 4'h0;
	end
	task automatic start();
		@(negedge clock) cs_n = 1'b0;
		repeat (6) @(negedge clock);
	endtask : start
	// Parks the clock low first so no edge lands after deselect.
	task automatic stop();
		@(negedge clock) sclk = 1'b0;
		repeat (4) @(negedge clock);
		cs_n = 1'b1;
		repeat (12) @(negedge clock);
	endtask : stop
	// Answer bits settle late, so they are taken at the end of the high phase.
	task automatic xfer(input logic [7:0] tx, input int ln, input int nb, output logic [7:0] rx);
		logic [7:0] sh;
		sh = tx;
		rx = 8'h00;
		for (int i = 0; i < nb; i += ln) begin
			sclk = 1'b0;
			io = (ln == 4) ? sh[7:4] : (ln == 2) ? {~io[3:2], sh[7:6]} : {~io[3:1], sh[7]};
			sh = sh << ln;
			repeat (4) @(negedge clock);
			sclk = 1'b1;
			repeat (4) @(negedge clock);
			rx = (ln == 4) ? {rx[3:0], line} : (ln == 2) ? {rx[5:0], line[1:0]} : {rx[6:0], line[1]};
		end
	endtask : xfer
endmodule : sfcfe_host_model
`default_nettype wire

// ### tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin errors++; \
	$display("Error t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb
	import sfcfe_pkg::*;
;
	// Identification values are arbitrary.
	localparam logic [7:0] MK = 8'h5E;
	localparam logic [7:0] MT = 8'h2B;
	localparam logic [7:0] CP = 8'h4D;
	localparam logic [7:0] PT = 8'h71;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic fl = 1'b0;
	logic busy = 1'b0;
	logic [7:0] st[3] = '{8'h1E, 8'h62, 8'hB4};
	int errors = 0;
	int cmp_count = 0;
	int n_commit = 0;
	int n_disc = 0;
	logic [7:0] wq[$];
	logic cs_n, sclk, commit, disc, wv, deep;
	logic [3:0] hio, io_out, oe, line;
	logic [7:0] op, wb, wrap, pd;
	logic [23:0] pa;
	logic [31:0] addr;
	sfcfe_power_e pw;
	assign line = (oe & io_out) | (~oe & hio);
	assign pd = pa[7:0] ^ 8'h96;
	always #25 clock = ~clock;
	always @(posedge clock) begin
		if (wv) wq.push_back(wb);
		if (commit) n_commit++;
		if (disc) n_disc++;
	end
	sfcfe_host_model host_inst (.clock(clock), .line(line), .cs_n(cs_n), .sclk(sclk), .io(hio));
	sfcfe_front_end #(.MAKER_CODE(MK), .MEMORY_TYPE(MT), .CAPACITY_CODE(CP), .PART_CODE(PT))
	sfcfe_front_end_inst (
		.clock(clock), .resetn(resetn), .spi_cs_n(cs_n), .spi_sclk(sclk), .spi_io_in(line),
		.spi_io_out(io_out), .spi_io_oe(oe), .four_lane_command_mode(fl), .busy_in(busy),
		.status1_byte(st[0]), .status2_byte(st[1]), .status3_byte(st[2]), .param_data(pd),
		.param_addr(pa), .cmd_commit(commit), .cmd_discard(disc), .cmd_opcode(op),
		.cmd_addr(addr), .wr_valid(wv), .wr_byte(wb), .wrap_setting(wrap), .deep_sleep(deep),
		.power_state(pw)
	);
	task automatic frame(input logic [7:0] b[$], input int ln, input int q, input int tail,
			output logic [7:0] r[$]);
		logic [7:0] x;
		r = {};
		host_inst.start();
		if (!deep) `CHK(pw, PWR_ACTIVE)
		foreach (b[i]) begin
			host_inst.xfer(b[i], fl ? 4 : (i == 0) ? 1 : (i >= q) ? 4 : ln, 8, x);
			r.push_back(x);
		end
		if (tail > 0) host_inst.xfer(8'hFF, 1, tail, x);
		host_inst.stop();
	endtask : frame
	task automatic t_ident();
		logic [7:0] r[$];
		frame({OP_STD_IDENT, 8'h0F, 8'hF0, 8'h3C, 8'hC3}, 1, 99, 0, r);
		`CHK({r[1], r[2], r[3], r[4]}, {MK, MT, CP, 8'h00})
		`CHK(oe, 4'h0)
		`CHK(pw, PWR_STANDBY)
		frame({OP_STD_IDENT, 8'h00}, 1, 99, 5, r);
		`CHK({n_commit, n_disc}, {32'd0, 32'd0})
	endtask : t_ident
	task automatic t_status();
		logic [7:0] r[$];
		logic [7:0] ops[3] = '{OP_STATUS1_READ, OP_STATUS2_READ, OP_STATUS3_READ};
		@(negedge clock) busy = 1'b1;
		for (int k = 0; k < 3; k++) begin
			frame({ops[k], 8'h00, 8'h00}, 1, 99, 0, r);
			`CHK({r[1], r[2]}, {st[k], st[k]})
		end
		`CHK(pw, PWR_ACTIVE)
		frame({OP_PROG_ADDR4, 8'h00, 8'h00, 8'h00, 8'h10, 8'h55}, 1, 99, 0, r);
		`CHK(n_commit + wq.size(), 0)
		frame({OP_SUSPEND}, 1, 99, 0, r);
		`CHK({n_commit, op}, {32'd1, OP_SUSPEND})
		@(negedge clock) busy = 1'b0;
	endtask : t_status
	task automatic t_prog();
		logic [7:0] r[$];
		frame({OP_PROG_ADDR4, 8'h89, 8'hAB, 8'hCD, 8'hEF, 8'h5A, 8'hC3}, 1, 99, 0, r);
		`CHK({op, addr, wq[0], wq[1]}, {OP_PROG_ADDR4, 32'h89AB_CDEF, 16'h5AC3})
		`CHK(n_commit, 2)
		frame({OP_PROG_ADDR4, 8'h00, 8'h00, 8'h00, 8'h00, 8'h11}, 1, 99, 3, r);
		`CHK({n_commit, n_disc}, {32'd2, 32'd1})
		wq = {};
		@(negedge clock) fl = 1'b1;
		frame({OP_QPROG_ADDR4, 8'h01, 8'h02, 8'h03, 8'h04, 8'hA7, 8'h6E}, 4, 99, 0, r);
		`CHK({addr, wq[0], wq[1]}, {32'h0102_0304, 16'hA76E})
		@(negedge clock) fl = 1'b0;
		frame({OP_QPROG_ADDR4, 8'h04, 8'h03, 8'h02, 8'h01, 8'h3D}, 1, 5, 0, r);
		`CHK({op, addr, wq[2]}, {OP_QPROG_ADDR4, 32'h0403_0201, 8'h3D})
	endtask : t_prog
	task automatic t_misc();
		logic [7:0] r[$];
		frame({OP_WRAP_SET, 8'hC1, 8'h7E, 8'h99, 8'h40}, 1, 99, 0, r);
		`CHK(wrap, 8'h40)
		frame({OP_PARAM_READ, 8'h00, 8'h01, 8'hFE, 8'h00, 8'h00, 8'h00}, 1, 99, 0, r);
		`CHK({r[5], r[6]}, {8'hFE ^ 8'h96, 8'hFF ^ 8'h96})
		frame({OP_MAKER_PART, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, 1, 99, 0, r);
		`CHK({r[4], r[5], r[6]}, {MK, PT, MK})
		frame({OP_MAKER_PART_X2, 8'h12, 8'h34, 8'h56, 8'hF0, 8'h00, 8'h00}, 2, 99, 0, r);
		`CHK({r[5], r[6]}, {MK, PT})
	endtask : t_misc
	task automatic t_deep();
		logic [7:0] r[$];
		frame({OP_DEEP_SLEEP_ENTRY}, 1, 99, 0, r);
		`CHK({deep, pw, n_commit}, {1'b1, PWR_DEEP, 32'd6})
		frame({OP_PROG_ADDR4, 8'h00, 8'h00, 8'h00, 8'h00, 8'hAA}, 1, 99, 0, r);
		`CHK({n_commit, oe}, {32'd6, 4'h0})
		frame({OP_WAKE_AND_IDENTIFY, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, 1, 99, 0, r);
		`CHK({deep, r[4], r[5]}, {1'b0, PT, PT})
		`CHK(pw, PWR_STANDBY)
	endtask : t_deep
	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : complete_run
	initial begin
		repeat (5) @(negedge clock);
		resetn = 1'b1;
		repeat (8) @(negedge clock);
		`CHK({pw, oe}, {PWR_STANDBY, 4'h0})
		t_ident();
		t_status();
		t_prog();
		t_misc();
		t_deep();
		complete_run();
	end
	// All frames together take well under a millisecond.
	initial begin
		#3_000_000;
		errors++;
		complete_run();
	end
endmodule : tb
`default_nettype wire
